// ---- prio_top.sv ----
`include "prio_defs.svh"
module prio_top (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] ext_line_i,
    input wire logic [3:0] port_upper_i,
    input wire logic [7:0] can_flags_i,
    input wire logic [7:0] can_enables_i,
    input wire logic timer_tick_i,
    input wire logic watchdog_timeout_i,
    input wire logic powerdown_i,
    input wire logic sleep_req_i,
    input wire logic int_ack_i,
    input wire logic [20:0] cur_pc_i,
    input wire logic [7:0] working_reg_i,
    input wire logic [7:0] status_reg_i,
    input wire logic [7:0] bank_select_reg_i,
    output logic irq_high_o,
    output logic irq_low_o,
    output logic sleeping_o,
    output logic wake_o,
    output logic wake_vector_o
);
    typedef struct packed {
        prio_pkg::prio_state_t state;
        logic [7:0] main_ctl;
        logic [7:0] second_ctl;
        logic [7:0] third_ctl;
        logic [7:0] can_prio;
        logic [7:0] rst_ctl;
        logic [7:0] tmr_ctl;
        logic [15:0] tmr_cnt;
        logic [2:0] ext_prev;
        logic [3:0] port_latch;
        logic [2:0] sleep_en;
        logic [23:0] ctx;
        logic [20:0] ret_pc;
        logic wake;
        logic wake_vec;
        logic [31:0] rdata;
    } prio_st_t;
    prio_st_t st_r;
    prio_st_t st_nxt;
    prio_sync_if sif ();
    logic [2:0] ext_s;
    logic [3:0] port_s;
    logic [2:0] ext_edge;
    logic [2:0] edge_sel;
    logic [2:0] ext_flag;
    logic [2:0] ext_en;
    logic priority_levels_enable;
    logic rd_en;
    logic rd_setup;
    logic wr_en;
    logic port_mismatch;
    logic tmr_ovf;
    logic [16:0] tmr_inc;
    logic [7:0] hi_src;
    logic [7:0] any_src;
    logic [7:0] src_prio;
    logic hi_req;
    logic lo_req;
    assign sif.raw = {port_upper_i, ext_line_i};
    prio_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .sif(sif)
    );
    assign ext_s = sif.clean[2:0];
    assign port_s = sif.clean[6:3];
    function automatic logic [7:0] wmerge(input logic [7:0] old,
                                          input logic [7:0] val,
                                          input logic [7:0] mask);
        wmerge = (old & ~mask) | (val & mask);
    endfunction
    assign pready = 1'b1;
    assign rd_en = psel && penable && !pwrite;
    // Data fetched in setup so it stands at the access edge
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign priority_levels_enable = st_r.rst_ctl[7];
    // Edge select bits: line 0 second bit 6, line 1 bit 5, line 2 bit 4
    assign edge_sel = {st_r.second_ctl[4], st_r.second_ctl[5],
                       st_r.second_ctl[6]};
    assign ext_flag = {st_r.third_ctl[1], st_r.third_ctl[0],
                       st_r.main_ctl[1]};
    assign ext_en = {st_r.third_ctl[4], st_r.third_ctl[3],
                     st_r.main_ctl[4]};
    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_edge
            assign ext_edge[g] = edge_sel[g] ?
                (ext_s[g] & ~st_r.ext_prev[g]) :
                (~ext_s[g] & st_r.ext_prev[g]);
        end
    endgenerate
    assign port_mismatch = |(port_s ^ st_r.port_latch);
    assign tmr_inc = {1'b0, st_r.tmr_cnt} + 17'h00001;
    assign tmr_ovf = timer_tick_i && (st_r.tmr_ctl[0] ?
        tmr_inc[16] : (st_r.tmr_cnt[7:0] == 8'hFF));
    // Sources: ext0, ext1, ext2, timer, port, CAN(any high), CAN(any low)
    assign any_src[0] = ext_flag[0] & ext_en[0];
    assign any_src[1] = ext_flag[1] & ext_en[1];
    assign any_src[2] = ext_flag[2] & ext_en[2];
    assign any_src[3] = st_r.main_ctl[2] & st_r.main_ctl[5];
    assign any_src[4] = st_r.main_ctl[0] & st_r.main_ctl[3];
    assign any_src[5] = |(can_flags_i & can_enables_i & st_r.can_prio);
    assign any_src[6] = |(can_flags_i & can_enables_i & ~st_r.can_prio);
    assign any_src[7] = 1'b0;
    assign src_prio = {1'b0, 1'b0, 1'b1, st_r.second_ctl[0],
                       st_r.second_ctl[2], st_r.third_ctl[7],
                       st_r.third_ctl[6], 1'b1};
    assign hi_src = any_src & src_prio;
    always_comb
    begin
        if (priority_levels_enable)
        begin
            // Two levels: high gated by high enable, low by both high and low enables
            hi_req = st_r.main_ctl[7] && (|hi_src);
            lo_req = st_r.main_ctl[7] && st_r.main_ctl[6] &&
                     (|(any_src & ~src_prio));
        end
        else
        begin
            // Legacy single level: all requests on the high line
            hi_req = st_r.main_ctl[7] && (|any_src);
            lo_req = 1'b0;
        end
    end
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ext_prev = ext_s;
        st_nxt.wake = 1'b0;
        st_nxt.wake_vec = 1'b0;
        st_nxt.rst_ctl[3] = watchdog_timeout_i;
        st_nxt.rst_ctl[2] = powerdown_i;
        st_nxt.rdata = 32'h00000000;
        if (timer_tick_i)
        begin
            st_nxt.tmr_cnt = st_r.tmr_ctl[0] ? tmr_inc[15:0] :
                             {8'h00, tmr_inc[7:0]};
        end
        if (rd_setup)
        begin
            if (paddr == `PRIO_ADDR_MAIN)
                st_nxt.rdata = {24'h000000, st_r.main_ctl};
            else if (paddr == `PRIO_ADDR_SECOND)
                st_nxt.rdata = {24'h000000, st_r.second_ctl};
            else if (paddr == `PRIO_ADDR_THIRD)
                st_nxt.rdata = {24'h000000, st_r.third_ctl};
            else if (paddr == `PRIO_ADDR_CANPRI)
                st_nxt.rdata = {24'h000000, st_r.can_prio};
            else if (paddr == `PRIO_ADDR_RSTCTL)
                st_nxt.rdata = {24'h000000, st_r.rst_ctl & 8'h9F};
            else if (paddr == `PRIO_ADDR_TIMER)
                st_nxt.rdata = {16'h0000, st_r.tmr_cnt};
            else if (paddr == `PRIO_ADDR_PORT)
            begin
                st_nxt.rdata = {28'h0000000, port_s};
            end
            else if (paddr == `PRIO_ADDR_CTX)
                st_nxt.rdata = {8'h00, st_r.ctx};
            else if (paddr == `PRIO_ADDR_RETPC)
                st_nxt.rdata = {11'h000, st_r.ret_pc};
        end
        if (rd_en && paddr == `PRIO_ADDR_PORT)
            st_nxt.port_latch = port_s;
        if (wr_en)
        begin
            if (paddr == `PRIO_ADDR_MAIN)
                st_nxt.main_ctl = pwdata[7:0];
            else if (paddr == `PRIO_ADDR_SECOND)
                st_nxt.second_ctl = wmerge(st_r.second_ctl, pwdata[7:0],
                                           `PRIO_SECOND_WMASK);
            else if (paddr == `PRIO_ADDR_THIRD)
                st_nxt.third_ctl = wmerge(st_r.third_ctl, pwdata[7:0],
                                          `PRIO_THIRD_WMASK);
            else if (paddr == `PRIO_ADDR_CANPRI)
                st_nxt.can_prio = pwdata[7:0];
            else if (paddr == `PRIO_ADDR_RSTCTL)
                st_nxt.rst_ctl = wmerge(st_nxt.rst_ctl, pwdata[7:0],
                                        `PRIO_RSTCTL_WMASK);
            else if (paddr == `PRIO_ADDR_TIMER)
            begin
                st_nxt.tmr_ctl = {7'h00, pwdata[16]};
                st_nxt.tmr_cnt = pwdata[15:0];
            end
            else if (paddr == `PRIO_ADDR_PORT)
                st_nxt.port_latch = port_s;
        end
        // Hardware sets win over software clears
        if (ext_edge[0])
            st_nxt.main_ctl[1] = 1'b1;
        if (ext_edge[1])
            st_nxt.third_ctl[0] = 1'b1;
        if (ext_edge[2])
            st_nxt.third_ctl[1] = 1'b1;
        if (tmr_ovf)
            st_nxt.main_ctl[2] = 1'b1;
        if (port_mismatch)
            st_nxt.main_ctl[0] = 1'b1;
        case (st_r.state)
            prio_pkg::PRIO_RUN:
            begin
                if (sleep_req_i)
                begin
                    st_nxt.state = prio_pkg::PRIO_SLEEP;
                    st_nxt.sleep_en = ext_en;
                end
                else if (hi_req || lo_req)
                begin
                    st_nxt.state = prio_pkg::PRIO_ENTRY;
                    st_nxt.ret_pc = cur_pc_i;
                    st_nxt.ctx = {working_reg_i, status_reg_i,
                                  bank_select_reg_i};
                end
            end
            prio_pkg::PRIO_SLEEP:
            begin
                // Enable state captured at sleep entry decides wake
                if (|(st_r.sleep_en & ext_flag))
                begin
                    st_nxt.state = prio_pkg::PRIO_RUN;
                    st_nxt.wake = 1'b1;
                    st_nxt.wake_vec = st_r.main_ctl[7];
                end
            end
            prio_pkg::PRIO_ENTRY:
            begin
                if (int_ack_i)
                    st_nxt.state = prio_pkg::PRIO_RUN;
            end
            default:
                st_nxt.state = prio_pkg::PRIO_RUN;
        endcase
    end
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_r <= '0;
            st_r.state <= prio_pkg::PRIO_RUN;
            st_r.main_ctl <= `PRIO_RST_MAIN;
            st_r.second_ctl <= `PRIO_RST_SECOND;
            st_r.third_ctl <= `PRIO_RST_THIRD;
            st_r.can_prio <= `PRIO_RST_CANPRI;
            st_r.rst_ctl <= `PRIO_RST_RSTCTL;
            st_r.tmr_ctl <= `PRIO_RST_TIMER;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign prdata = st_r.rdata;
    assign pslverr = 1'b0;
    assign irq_high_o = hi_req;
    assign irq_low_o = lo_req;
    assign sleeping_o = (st_r.state == prio_pkg::PRIO_SLEEP);
    assign wake_o = st_r.wake;
    assign wake_vector_o = st_r.wake_vec;
endmodule

// ---- prio_defs.svh ----
`ifndef PRIO_DEFS_SVH
`define PRIO_DEFS_SVH
`define PRIO_ADDR_MAIN 12'h000
`define PRIO_ADDR_SECOND 12'h004
`define PRIO_ADDR_THIRD 12'h008
`define PRIO_ADDR_CANPRI 12'h00C
`define PRIO_ADDR_RSTCTL 12'h010
`define PRIO_ADDR_TIMER 12'h014
`define PRIO_ADDR_PORT 12'h018
`define PRIO_ADDR_CTX 12'h01C
`define PRIO_ADDR_RETPC 12'h020
`define PRIO_RST_MAIN 8'h00
`define PRIO_RST_SECOND 8'hF5
`define PRIO_RST_THIRD 8'hC0
`define PRIO_RST_CANPRI 8'hFF
`define PRIO_RST_RSTCTL 8'h1C
`define PRIO_RST_TIMER 8'h00
`define PRIO_RSTCTL_WMASK 8'h93
`define PRIO_SECOND_WMASK 8'hF5
`define PRIO_THIRD_WMASK 8'hDB
`endif

// ---- prio_pkg.sv ----
package prio_pkg;
    typedef enum logic [1:0] {
        PRIO_RUN = 2'b00,
        PRIO_SLEEP = 2'b01,
        PRIO_ENTRY = 2'b10
    } prio_state_t;
endpackage

// ---- prio_sync_if.sv ----
interface prio_sync_if;
    logic [6:0] raw;
    logic [6:0] clean;
    modport src (output raw, input clean);
    modport snk (input raw, output clean);
endinterface

// ---- prio_sync.sv ----
module prio_sync (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    prio_sync_if.snk sif
);
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] s3;
        logic [6:0] clean;
    } prio_sync_st_t;
    prio_sync_st_t st_r;
    prio_sync_st_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = sif.raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Accept only when second and third stages agree
        for (int i = 0; i < 7; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.clean[i] = st_r.s3[i];
            end
        end
    end
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign sif.clean = st_r.clean;
endmodule

// ---- prio_top_sva.sv ----
`include "prio_defs.svh"
module prio_top_sva (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_low_o,
    input wire logic sleeping_o,
    input wire logic wake_o,
    input wire logic wake_vector_o
);
    logic rd_acc;
    logic priority_levels_enable_r;
    logic priority_levels_enable_nxt;
    assign rd_acc = psel && penable && !pwrite;
    // Shadow of the levels bit, tracked from bus writes only
    always_comb
    begin
        priority_levels_enable_nxt = priority_levels_enable_r;
        if (psel && penable && pwrite && pstrb[0]
            && paddr == `PRIO_ADDR_RSTCTL)
            priority_levels_enable_nxt = pwdata[7];
    end
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            priority_levels_enable_r <= 1'b0;
        else
            priority_levels_enable_r <= priority_levels_enable_nxt;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_rst_rd;
        rd_acc && paddr == `PRIO_ADDR_RSTCTL;
    endsequence
    sequence s_rsv_zero;
        prdata[6:5] == 2'h0 && prdata[31:8] == 24'h0;
    endsequence
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_no_error: assert property (!pslverr)
        else $error("pslverr raised");
    chk_rdata_idle: assert property (!rd_acc |-> prdata == 32'h0)
        else $error("read data outside read answer");
    chk_rsv_zero: assert property (s_rst_rd |-> s_rsv_zero)
        else $error("reserved bits not zero");
    chk_legacy_low: assert property (!priority_levels_enable_r |-> !irq_low_o)
        else $error("low request in single level mode");
    chk_wake_pulse: assert property (wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    chk_vector_wake: assert property (wake_vector_o |-> wake_o)
        else $error("vector without wake");
    chk_wake_sleep: assert property ($rose(wake_o) |-> $past(sleeping_o))
        else $error("wake while awake");
endmodule
bind prio_top prio_top_sva prio_top_sva_i (.*);

// ---- prio_core_model.sv ----
module prio_core_model (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic irq_i,
    input wire logic slow_i,
    output logic ack_o
);
    int wait_n;
    logic pend;
    // Fetch delay varies so entry is seen both quickly and late
    always @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ack_o <= 1'b0;
            wait_n = 0;
            pend = 1'b0;
        end
        else
        begin
            ack_o <= 1'b0;
            // Entry once seen is always acknowledged, even if irq drops
            if (irq_i && !ack_o)
                pend = 1'b1;
            if (pend)
                wait_n++;
            if (wait_n > (slow_i ? 5 : 1))
            begin
                ack_o <= 1'b1;
                wait_n = 0;
                pend = 1'b0;
            end
        end
    end
endmodule

// ---- tb_priority_interrupt_logic.sv ----
`include "prio_defs.svh"
module tb_priority_interrupt_logic;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0, reset_i = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, int_ack_i, slow = 1'b0, sel;
    logic [2:0] ext_line_i = 3'h0;
    logic [3:0] port_upper_i = 4'h0;
    logic [7:0] can_flags_i = 8'h0, can_enables_i = 8'h0;
    logic timer_tick_i = 1'b0, sleep_req_i = 1'b0;
    logic watchdog_timeout_i = 1'b0, powerdown_i = 1'b0;
    logic [20:0] cur_pc_i;
    logic [7:0] working_reg_i, status_reg_i, bank_select_reg_i;
    logic irq_high_o, irq_low_o, sleeping_o, wake_o, wake_vector_o;
    logic [11:0] fa;
    int fails = 0, samples_checked = 0, k;
    logic [7:0] m [0:4] = '{`PRIO_RST_MAIN, `PRIO_RST_SECOND,
        `PRIO_RST_THIRD, `PRIO_RST_CANPRI, `PRIO_RST_RSTCTL};
    logic [7:0] wm [0:4] = '{8'hFF, `PRIO_SECOND_WMASK,
        `PRIO_THIRD_WMASK, 8'hFF, `PRIO_RSTCTL_WMASK};
    always #10 ref_clk_i = ~ref_clk_i;
    prio_top prio_top_i (.*);
    prio_core_model prio_core_model_i (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .irq_i(irq_high_o | irq_low_o),
        .slow_i(slow), .ack_o(int_ack_i));
    task give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        n = 0;
        @(posedge ref_clk_i);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                fails++;
                give_verdict();
            end
            @(posedge ref_clk_i);
        end
        // Read data taken at the access edge itself
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge ref_clk_i);
        if (w && a < 12'h014)
            m[a>>2] = (m[a>>2] & ~wm[a>>2]) | (d[7:0] & wm[a>>2]);
    endtask
    task cmp_v(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task cmp(input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
        xfer(1'b0, a, 32'h0);
        cmp_v(q & mk, e & mk);
    endtask
    task edge_to(input int i, input logic v);
        @(posedge ref_clk_i);
        ext_line_i[i] <= v;
        repeat (6) @(posedge ref_clk_i);
    endtask
    task tick();
        @(posedge ref_clk_i);
        timer_tick_i <= 1'b1;
        @(posedge ref_clk_i);
        timer_tick_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask
    initial
    begin
        k = $urandom(70);
        cur_pc_i = 21'($urandom);
        {working_reg_i, status_reg_i, bank_select_reg_i} = 24'($urandom);
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        for (k = 0; k < 5; k++)
            cmp(12'(k * 4), {24'h0, m[k]}, k == 4 ? 32'hF3 : 32'hFF);
        xfer(1'b1, `PRIO_ADDR_CANPRI, $urandom);
        cmp(`PRIO_ADDR_CANPRI, {24'h0, m[3]}, 32'hFF);
        xfer(1'b1, `PRIO_ADDR_RSTCTL, 32'hFF);
        cmp(`PRIO_ADDR_RSTCTL, {24'h0, m[4]}, 32'hF3);
        xfer(1'b1, 12'h040, 32'hFF);
        cmp(12'h040, 32'h0, 32'hFFFFFFFF);
        xfer(1'b1, `PRIO_ADDR_RSTCTL, 32'h10);
        can_enables_i <= 8'($urandom);
        xfer(1'b0, `PRIO_ADDR_PORT, 32'h0);
        xfer(1'b1, `PRIO_ADDR_MAIN, 32'hC8);
        @(posedge ref_clk_i);
        port_upper_i <= 4'($urandom) | 4'h1;
        repeat (6) @(posedge ref_clk_i);
        cmp(`PRIO_ADDR_MAIN, 32'h1, 32'h1);
        cmp_v({30'h0, irq_high_o, irq_low_o}, 32'h2);
        xfer(1'b1, `PRIO_ADDR_RSTCTL, 32'h90);
        xfer(1'b1, `PRIO_ADDR_SECOND, 32'hF4);
        cmp_v({30'h0, irq_high_o, irq_low_o}, 32'h1);
        xfer(1'b0, `PRIO_ADDR_PORT, 32'h0);
        xfer(1'b1, `PRIO_ADDR_MAIN, 32'h0);
        repeat (6) @(posedge ref_clk_i);
        cmp(`PRIO_ADDR_MAIN, 32'h0, 32'h1);
        cmp(`PRIO_ADDR_CTX, {8'h0, working_reg_i, status_reg_i,
            bank_select_reg_i}, 32'hFFFFFF);
        cmp(`PRIO_ADDR_RETPC, {11'h0, cur_pc_i}, 32'h1FFFFF);
        for (k = 0; k < 3; k++)
        begin
            sel = 1'($urandom);
            edge_to(k, sel);
            xfer(1'b1, `PRIO_ADDR_SECOND, 32'(sel ? m[1] | (8'h40 >> k)
                : m[1] & ~(8'h40 >> k)));
            xfer(1'b1, `PRIO_ADDR_MAIN, 32'h0);
            xfer(1'b1, `PRIO_ADDR_THIRD, 32'hC0);
            fa = k ? `PRIO_ADDR_THIRD : `PRIO_ADDR_MAIN;
            edge_to(k, !sel);
            cmp(fa, 32'h0, k ? k : 2);
            edge_to(k, sel);
            cmp(fa, k ? k : 2, k ? k : 2);
        end
        for (k = 0; k < 2; k++)
        begin
            xfer(1'b1, `PRIO_ADDR_MAIN, 32'h0);
            xfer(1'b1, `PRIO_ADDR_TIMER, k ? 32'h1FFFE : 32'hFE);
            tick();
            cmp(`PRIO_ADDR_MAIN, 32'h0, 32'h4);
            tick();
            cmp(`PRIO_ADDR_MAIN, 32'h4, 32'h4);
        end
        xfer(1'b1, `PRIO_ADDR_SECOND, 32'hF5);
        edge_to(0, 1'b0);
        xfer(1'b1, `PRIO_ADDR_MAIN, 32'h0);
        xfer(1'b1, `PRIO_ADDR_MAIN, 32'h90);
        @(posedge ref_clk_i);
        slow <= 1'b1;
        sleep_req_i <= 1'b1;
        @(posedge ref_clk_i);
        sleep_req_i <= 1'b0;
        @(negedge ref_clk_i);
        cmp_v({31'h0, sleeping_o}, 32'h1);
        @(posedge ref_clk_i);
        ext_line_i[0] <= 1'b1;
        k = 0;
        while (wake_o !== 1'b1 && k < 20)
        begin
            @(negedge ref_clk_i);
            k++;
        end
        cmp_v({30'h0, wake_o, wake_vector_o}, 32'h3);
        give_verdict();
    end
endmodule
